// *** rtl/clock_request_controller.sv ***
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "clock_controller_defs.svh"
module clock_request_controller
    import clock_controller_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fast_osc_tick,
    input wire logic slow_osc_tick,
    input wire logic ext_clock_pin,
    input wire logic fast_analog_ready,
    input wire logic slow_analog_ready,
    input wire clock_request_type peripheral_request,
    input wire logic rtc_enabled,
    input wire logic wdt_enabled,
    input wire logic bod_enabled,
    input wire logic bod_sampled_mode,
    input wire sleep_mode_type sleep_mode,
    input wire logic nvm_busy,
    input wire fuse_values_type fuses,
    output logic fast_osc_enable,
    output logic slow_osc_enable,
    output logic ext_pin_clock_select,
    output logic [1:0] main_source,
    output logic main_clock_gate,
    output logic cpu_clock_tick,
    output logic per_clock_tick,
    output logic kilo_tick,
    output logic rtc_clock_request,
    output logic wdt_clock_request,
    output logic bod_clock_request,
    output logic [5:0] fast_calibration,
    output logic [3:0] temperature_calibration,
    output logic fast_osc_center_20mhz
);

    state_type q;
    state_type d;

    function automatic logic [1:0] slot_of(input logic [1:0] code);
        logic [1:0] s;
        s = `SLOT_FAST;
        if (code == `SRC_SLOW) begin
            s = `SLOT_SLOW;
        end else if (code == `SRC_EXT) begin
            s = `SLOT_EXT;
        end
        return s;
    endfunction

    // Division factor; zero marks a reserved code
    function automatic logic [6:0] factor_of(input logic [3:0] code);
        logic [6:0] f;
        case (code)
            4'h0: f = 7'h02;
            4'h1: f = 7'h04;
            4'h2: f = 7'h08;
            4'h3: f = 7'h10;
            4'h4: f = 7'h20;
            4'h5: f = 7'h40;
            4'h8: f = 7'h06;
            4'h9: f = 7'h0a;
            4'ha: f = 7'h0c;
            4'hb: f = 7'h18;
            4'hc: f = 7'h30;
            default: f = 7'h00;
        endcase
        return f;
    endfunction

    logic [2:0] edge_seen;
    logic [2:0] analog_ok;
    logic [2:0] periph_want;
    logic [2:0] standby_force;
    logic [2:0] want;
    logic [2:0] stable;
    logic [2:0][2:0] target;
    logic [1:0] cur_slot;
    logic [1:0] sel_slot;
    logic pending;
    logic run;
    logic main_tick;
    logic [6:0] factor;
    logic [7:0] index;
    logic [7:0] wbyte;
    logic setup;
    logic wr;
    logic key_ok;
    logic cal_locked;
    logic mapped;
    logic [31:0] rdata;

    always_comb begin
        d = q;
        edge_seen = '0;
        analog_ok = '0;
        periph_want = '0;
        standby_force = '0;
        want = '0;
        stable = '0;
        target = '0;
        cur_slot = slot_of(q.current_source);
        sel_slot = slot_of(q.source_select);
        pending = q.source_select != q.current_source;
        run = 1'b0;
        main_tick = 1'b0;
        factor = '0;
        index = paddr[9:2];
        wbyte = pwdata[7:0];
        setup = psel & ~penable;
        wr = psel & penable & pwrite & q.pready & ~q.pslverr;
        key_ok = q.key_cnt != 3'h0;
        cal_locked = 1'b0;
        mapped = 1'b0;
        rdata = '0;

        // Pins and oscillator edges cross in through two flops
        d.sync1 = {slow_analog_ready, fast_analog_ready, ext_clock_pin, slow_osc_tick, fast_osc_tick};
        d.sync2 = q.sync1;
        d.prev_edge = q.sync2[2:0];
        edge_seen = q.sync2[2:0] & ~q.prev_edge;
        analog_ok = {1'b1, q.sync2[4], q.sync2[3]};

        d.rtc_request = rtc_enabled;
        d.wdt_request = wdt_enabled;
        d.bod_request = bod_enabled & bod_sampled_mode;
        periph_want[`SLOT_FAST] = peripheral_request.fast;
        periph_want[`SLOT_SLOW] = peripheral_request.slow | q.rtc_request | q.wdt_request | q.bod_request;
        periph_want[`SLOT_EXT] = peripheral_request.ext;
        standby_force = {1'b0, q.slow_run_in_standby, q.fast_run_in_standby};

        case (sleep_mode)
            SLEEP_ACTIVE: run = 1'b1;
            SLEEP_IDLE: run = 1'b1;
            SLEEP_STANDBY: run = periph_want[cur_slot] | standby_force[cur_slot];
            default: run = nvm_busy;
        endcase

        // Stable comes from registered counters, which are cleared whenever unrequested
        for (int i = 0; i < 3; i++) begin
            target[i] = (i == 2) ? `EXT_START_EDGES : `OSC_GATE_EDGES;
            stable[i] = q.start_cnt[i] == target[i];
            want[i] = periph_want[i] | (run & ((cur_slot == 2'(i)) | (pending & (sel_slot == 2'(i)))));
            d.osc_enable[i] = want[i] | (standby_force[i] & (sleep_mode != SLEEP_POWER_DOWN));
            if (!want[i] || !analog_ok[i]) begin
                d.start_cnt[i] = 3'h0;
            end else if (edge_seen[i] && !stable[i]) begin
                d.start_cnt[i] = q.start_cnt[i] + 3'h1;
            end
        end

        // Hold the old source until the new one is counted stable
        if (pending && stable[sel_slot]) begin
            d.current_source = q.source_select;
        end

        main_tick = run & stable[cur_slot] & edge_seen[cur_slot];
        d.main_gate = run & stable[cur_slot];
        d.cpu_tick = main_tick;
        factor = factor_of(q.prescaler_division);
        d.per_tick = 1'b0;
        if (!q.prescaler_enable) begin
            d.per_tick = main_tick;
            d.main_cnt = 7'h00;
        end else if (main_tick) begin
            if (q.main_cnt >= factor - 7'h01) begin
                d.main_cnt = 7'h00;
                d.per_tick = 1'b1;
            end else begin
                d.main_cnt = q.main_cnt + 7'h01;
            end
        end

        d.kilo_tick = 1'b0;
        if (stable[`SLOT_SLOW] && edge_seen[`SLOT_SLOW]) begin
            if (q.kilo_cnt == `KILO_DIVIDE) begin
                d.kilo_cnt = 5'h00;
                d.kilo_tick = 1'b1;
            end else begin
                d.kilo_cnt = q.kilo_cnt + 5'h01;
            end
        end

        // Fuses are caught on the first edge after reset release
        if (!q.loaded) begin
            d.loaded = 1'b1;
            d.frequency_calibration = fuses.frequency_calibration;
            d.temperature_slope_calibration = fuses.temperature_slope_calibration;
            d.oscillator_lock_fuse = fuses.oscillator_lock_fuse;
            d.lock_enable = fuses.oscillator_lock_fuse;
            d.center_20mhz = fuses.frequency_select_fuse;
        end

        cal_locked = q.oscillator_lock_fuse | (q.lock_enable & (q.current_source == `SRC_FAST));

        if (index == `REG_MAIN_CLOCK_CONTROL_A) begin
            mapped = 1'b1;
            rdata[1:0] = q.source_select;
        end else if (index == `REG_MAIN_CLOCK_CONTROL_B) begin
            mapped = 1'b1;
            rdata[4:0] = {q.prescaler_division, q.prescaler_enable};
        end else if (index == `REG_MAIN_CLOCK_LOCK) begin
            mapped = 1'b1;
            rdata[0] = q.lock_enable & 1'b0;
        end else if (index == `REG_MAIN_CLOCK_STATUS) begin
            mapped = 1'b1;
            rdata[`STAT_EXT_BIT] = stable[`SLOT_EXT];
            rdata[`STAT_SLOW_BIT] = stable[`SLOT_SLOW];
            rdata[`STAT_FAST_BIT] = stable[`SLOT_FAST];
            rdata[`STAT_PENDING_BIT] = pending;
        end else if (index == `REG_FAST_OSC_CONTROL) begin
            mapped = 1'b1;
            rdata[`RUN_IN_STANDBY_BIT] = q.fast_run_in_standby;
        end else if (index == `REG_FAST_OSC_CALIBRATION_A) begin
            mapped = 1'b1;
            rdata[5:0] = q.frequency_calibration;
        end else if (index == `REG_FAST_OSC_CALIBRATION_B) begin
            mapped = 1'b1;
            rdata[`CAL_LOCK_BIT] = q.oscillator_lock_fuse;
            rdata[3:0] = q.temperature_slope_calibration;
        end else if (index == `REG_SLOW_OSC_CONTROL) begin
            mapped = 1'b1;
            rdata[`RUN_IN_STANDBY_BIT] = q.slow_run_in_standby;
        end else if (index == `REG_CHANGE_PROTECTION) begin
            mapped = 1'b1;
        end

        // Answer one cycle after setup; unmapped or misaligned gives an error
        d.pready = setup;
        if (setup) begin
            d.pslverr = ~mapped | (paddr[1:0] != 2'h0) | (paddr[11:10] != 2'h0);
            d.prdata = pwrite ? 32'h0000_0000 : rdata;
        end

        if (key_ok) begin
            d.key_cnt = q.key_cnt - 3'h1;
        end

        if (wr) begin
            if (index == `REG_CHANGE_PROTECTION) begin
                if (wbyte == `IO_REGISTER_KEY) begin
                    d.key_cnt = `KEY_WINDOW_CYCLES;
                end
            end else if (key_ok) begin
                d.key_cnt = 3'h0;
                if (index == `REG_MAIN_CLOCK_CONTROL_A) begin
                    // A pending external switch can only be undone by reset
                    if (!q.lock_enable && wbyte[1:0] != `SRC_RESERVED &&
                        !(pending && q.source_select == `SRC_EXT)) begin
                        d.source_select = wbyte[1:0];
                    end
                end else if (index == `REG_MAIN_CLOCK_CONTROL_B) begin
                    if (!q.lock_enable && factor_of(wbyte[4:1]) != 7'h00) begin
                        d.prescaler_division = wbyte[4:1];
                        d.prescaler_enable = wbyte[0];
                    end
                end else if (index == `REG_MAIN_CLOCK_LOCK) begin
                    if (!q.lock_enable) begin
                        d.lock_enable = wbyte[0];
                    end
                end else if (index == `REG_FAST_OSC_CONTROL) begin
                    d.fast_run_in_standby = wbyte[`RUN_IN_STANDBY_BIT];
                end else if (index == `REG_FAST_OSC_CALIBRATION_A) begin
                    if (!cal_locked) begin
                        d.frequency_calibration = wbyte[5:0];
                    end
                end else if (index == `REG_FAST_OSC_CALIBRATION_B) begin
                    if (!cal_locked) begin
                        d.temperature_slope_calibration = wbyte[3:0];
                    end
                end else if (index == `REG_SLOW_OSC_CONTROL) begin
                    d.slow_run_in_standby = wbyte[`RUN_IN_STANDBY_BIT];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.source_select <= `RESET_SOURCE;
            q.current_source <= `RESET_SOURCE;
            q.prescaler_enable <= `RESET_PRESCALER_ENABLE;
            q.prescaler_division <= `RESET_DIVISION;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign fast_osc_enable = q.osc_enable[`SLOT_FAST];
    assign slow_osc_enable = q.osc_enable[`SLOT_SLOW];
    assign ext_pin_clock_select = q.osc_enable[`SLOT_EXT];
    assign main_source = q.current_source;
    assign main_clock_gate = q.main_gate;
    assign cpu_clock_tick = q.cpu_tick;
    assign per_clock_tick = q.per_tick;
    assign kilo_tick = q.kilo_tick;
    assign rtc_clock_request = q.rtc_request;
    assign wdt_clock_request = q.wdt_request;
    assign bod_clock_request = q.bod_request;
    assign fast_calibration = q.frequency_calibration;
    assign temperature_calibration = q.temperature_slope_calibration;
    assign fast_osc_center_20mhz = q.center_20mhz;

endmodule

// *** pkg/clock_controller_defs.svh ***
`ifndef CLOCK_CONTROLLER_DEFS_SVH
`define CLOCK_CONTROLLER_DEFS_SVH

// Register indices; byte address is four times the index
`define REG_MAIN_CLOCK_CONTROL_A 8'h00
`define REG_MAIN_CLOCK_CONTROL_B 8'h01
`define REG_MAIN_CLOCK_LOCK 8'h02
`define REG_MAIN_CLOCK_STATUS 8'h03
`define REG_FAST_OSC_CONTROL 8'h10
`define REG_FAST_OSC_CALIBRATION_A 8'h11
`define REG_FAST_OSC_CALIBRATION_B 8'h12
`define REG_SLOW_OSC_CONTROL 8'h18
`define REG_CHANGE_PROTECTION 8'h20

// Source select codes
`define SRC_FAST 2'h0
`define SRC_SLOW 2'h1
`define SRC_RESERVED 2'h2
`define SRC_EXT 2'h3

// Source slot numbers inside per-source vectors
`define SLOT_FAST 2'h0
`define SLOT_SLOW 2'h1
`define SLOT_EXT 2'h2

// Field positions
`define RUN_IN_STANDBY_BIT 1
`define CAL_LOCK_BIT 7
`define STAT_EXT_BIT 7
`define STAT_SLOW_BIT 5
`define STAT_FAST_BIT 4
`define STAT_PENDING_BIT 0

// Reset values
`define RESET_SOURCE 2'h0
`define RESET_DIVISION 4'h8
`define RESET_PRESCALER_ENABLE 1'b1

// Protection key and its window in pclk cycles
`define IO_REGISTER_KEY 8'hd8
`define KEY_WINDOW_CYCLES 3'h4

// Start-up edge counts
`define OSC_GATE_EDGES 3'h4
`define EXT_START_EDGES 3'h2

// Low-power oscillator edges per 1 kHz tick, minus one
`define KILO_DIVIDE 5'h1f

`endif

// *** pkg/clock_controller_pkg.sv ***
package clock_controller_pkg;

    typedef enum logic [1:0] {
        SLEEP_ACTIVE,
        SLEEP_IDLE,
        SLEEP_STANDBY,
        SLEEP_POWER_DOWN
    } sleep_mode_type;

    typedef struct packed {
        logic fast;
        logic slow;
        logic ext;
    } clock_request_type;

    typedef struct packed {
        logic [5:0] frequency_calibration;
        logic [3:0] temperature_slope_calibration;
        logic frequency_select_fuse;
        logic oscillator_lock_fuse;
    } fuse_values_type;

    typedef struct packed {
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic [2:0] prev_edge;
        logic [2:0][2:0] start_cnt;
        logic loaded;
        logic [1:0] source_select;
        logic [1:0] current_source;
        logic prescaler_enable;
        logic [3:0] prescaler_division;
        logic lock_enable;
        logic fast_run_in_standby;
        logic slow_run_in_standby;
        logic [5:0] frequency_calibration;
        logic [3:0] temperature_slope_calibration;
        logic oscillator_lock_fuse;
        logic center_20mhz;
        logic [2:0] key_cnt;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [6:0] main_cnt;
        logic per_tick;
        logic cpu_tick;
        logic main_gate;
        logic [4:0] kilo_cnt;
        logic kilo_tick;
        logic [2:0] osc_enable;
        logic rtc_request;
        logic wdt_request;
        logic bod_request;
    } state_type;

endpackage

// *** bench/clock_request_controller_assertions.sv ***
`timescale 1ns/10ps
module clock_request_controller_assertions
    import clock_controller_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire clock_request_type peripheral_request,
    input wire logic bod_enabled,
    input wire logic bod_sampled_mode,
    input wire sleep_mode_type sleep_mode,
    input wire logic nvm_busy,
    input wire fuse_values_type fuses,
    input wire logic fast_osc_enable,
    input wire logic ext_pin_clock_select,
    input wire logic [1:0] main_source,
    input wire logic main_clock_gate,
    input wire logic cpu_clock_tick,
    input wire logic kilo_tick,
    input wire logic bod_clock_request,
    input wire logic [5:0] fast_calibration,
    input wire logic fast_osc_center_20mhz
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_SOURCE_CODE: assert property (main_source != 2'h2)
        else $error("reserved source active");
    AST_RESET_SOURCE: assert property ($rose(presetn) |-> main_source == 2'h0)
        else $error("source after reset");
    AST_FUSE_LOAD: assert property ($rose(presetn) |=> fast_calibration == fuses.frequency_calibration
        && fast_osc_center_20mhz == fuses.frequency_select_fuse) else $error("fuse load");
    AST_FAST_ON_REQUEST: assert property (peripheral_request.fast && sleep_mode != SLEEP_POWER_DOWN
        |=> fast_osc_enable) else $error("fast not started");
    AST_EXT_PIN: assert property (peripheral_request.ext |=> ext_pin_clock_select)
        else $error("pin not overridden");
    AST_POWER_DOWN_NVM: assert property ($fell(main_clock_gate) && sleep_mode == SLEEP_POWER_DOWN
        |-> !$past(nvm_busy)) else $error("stopped during nvm");
    AST_BOD_REQUEST: assert property ((bod_enabled && bod_sampled_mode) [*2] |-> bod_clock_request)
        else $error("bod request");
    AST_STOPPED_NO_TICK: assert property (!main_clock_gate [*2] |-> !cpu_clock_tick)
        else $error("tick while stopped");
    AST_KILO_SPACING: assert property (kilo_tick |=> !kilo_tick [*8])
        else $error("kilo ticks too close");
    AST_APB_ANSWER: assert property (psel && !penable |=> pready)
        else $error("no ready");
endmodule
bind clock_request_controller clock_request_controller_assertions checker_inst (.pclk, .presetn, .psel,
    .penable, .pready, .peripheral_request, .bod_enabled, .bod_sampled_mode, .sleep_mode, .nvm_busy, .fuses,
    .fast_osc_enable, .ext_pin_clock_select, .main_source, .main_clock_gate, .cpu_clock_tick, .kilo_tick,
    .bod_clock_request, .fast_calibration, .fast_osc_center_20mhz);

// *** bench/osc_model.sv ***
`timescale 1ns/10ps
module osc_model (
    input wire logic pclk,
    input wire logic fast_enable,
    input wire logic slow_enable,
    input wire logic ext_run,
    output logic fast_tick,
    output logic slow_tick,
    output logic ext_tick,
    output logic fast_ready,
    output logic slow_ready
);
    int cnt = 0;
    logic [3:0] fast_age = 4'h0;
    logic [3:0] slow_age = 4'h0;
    initial fast_tick = 1'b0;
    initial slow_tick = 1'b0;
    initial ext_tick = 1'b0;
    // A stopped oscillator holds its output low
    always @(posedge pclk) begin
        cnt <= cnt + 1;
        fast_tick <= fast_enable && cnt[1];
        slow_tick <= slow_enable && cnt[2];
        ext_tick <= ext_run && (cnt % 6 < 3);
        fast_age <= !fast_enable ? 4'h0 : (fast_age == 4'hf) ? fast_age : fast_age + 4'h1;
        slow_age <= !slow_enable ? 4'h0 : (slow_age == 4'hf) ? slow_age : slow_age + 4'h1;
    end
    // Analog start-up delay before the gate counts edges
    assign fast_ready = fast_age > 4'h5;
    assign slow_ready = slow_age > 4'h7;
endmodule

// *** bench/test_clock_request_controller.sv ***
`timescale 1ns/10ps
`include "clock_controller_defs.svh"
module test_clock_request_controller;
    import clock_controller_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext_run = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, fast_osc_tick, slow_osc_tick, ext_clock_pin, fast_analog_ready, slow_analog_ready;
    logic rtc_enabled = 1'b0, wdt_enabled = 1'b0, bod_enabled = 1'b0, bod_sampled_mode = 1'b0, nvm_busy = 1'b0;
    clock_request_type peripheral_request = '0;
    sleep_mode_type sleep_mode = SLEEP_ACTIVE;
    fuse_values_type fuses = {6'h25, 4'h9, 1'b1, 1'b0};
    logic fast_osc_enable, slow_osc_enable, ext_pin_clock_select, main_clock_gate, cpu_clock_tick, per_clock_tick;
    logic kilo_tick, rtc_clock_request, wdt_clock_request, bod_clock_request, fast_osc_center_20mhz;
    logic [1:0] main_source;
    logic [5:0] fast_calibration;
    logic [3:0] temperature_calibration;
    int num_errors = 0;
    int checked = 0;
    always #2 pclk = ~pclk;
    clock_request_controller DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .fast_osc_tick, .slow_osc_tick, .ext_clock_pin, .fast_analog_ready, .slow_analog_ready,
        .peripheral_request, .rtc_enabled, .wdt_enabled, .bod_enabled, .bod_sampled_mode, .sleep_mode, .nvm_busy,
        .fuses, .fast_osc_enable, .slow_osc_enable, .ext_pin_clock_select, .main_source, .main_clock_gate,
        .cpu_clock_tick, .per_clock_tick, .kilo_tick, .rtc_clock_request, .wdt_clock_request, .bod_clock_request,
        .fast_calibration, .temperature_calibration, .fast_osc_center_20mhz);
    osc_model partner (.pclk, .fast_enable(fast_osc_enable), .slow_enable(slow_osc_enable), .ext_run,
        .fast_tick(fast_osc_tick), .slow_tick(slow_osc_tick), .ext_tick(ext_clock_pin),
        .fast_ready(fast_analog_ready), .slow_ready(slow_analog_ready));
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Leaves the bus requested so a following transfer can start at once
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            num_errors++;
            $display("[FAIL] %0t no ready", $time);
        end
        rd = prdata;
        er = pslverr;
    endtask
    task automatic idle();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
        idle();
    endtask
    task automatic kwr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, `REG_CHANGE_PROTECTION, {24'h0, `IO_REGISTER_KEY});
        wr(idx, d);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        idle();
        check(rd, exp);
    endtask
    task automatic wait_src(input logic [1:0] s);
        for (int n = 0; n < 3000 && main_source !== s; n++) @(posedge pclk);
    endtask
    task automatic wait_gate(input logic g);
        for (int n = 0; n < 3000 && main_clock_gate !== g; n++) @(posedge pclk);
    endtask
    task automatic wait_per();
        for (int n = 0; n < 1000 && per_clock_tick !== 1'b1; n++) @(posedge pclk);
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask
    task automatic t_reset_values();
        rd_chk(`REG_MAIN_CLOCK_CONTROL_A, 32'h0);
        rd_chk(`REG_MAIN_CLOCK_CONTROL_B, 32'h11);
        rd_chk(`REG_FAST_OSC_CALIBRATION_A, {26'h0, fuses.frequency_calibration});
        rd_chk(`REG_FAST_OSC_CALIBRATION_B, {28'h0, fuses.temperature_slope_calibration});
        check({31'h0, fast_osc_center_20mhz}, 32'h1);
        apb(1'b0, 8'h05, 32'h0);
        idle();
        check({31'h0, er}, 32'h1);
        $display("done: reset values");
    endtask
    task automatic t_protect();
        wr(`REG_MAIN_CLOCK_CONTROL_B, 32'h03);
        rd_chk(`REG_MAIN_CLOCK_CONTROL_B, 32'h11);
        kwr(`REG_MAIN_CLOCK_CONTROL_B, 32'h0b);
        rd_chk(`REG_MAIN_CLOCK_CONTROL_B, 32'h0b);
        kwr(`REG_FAST_OSC_CALIBRATION_A, 32'h2a);
        rd_chk(`REG_FAST_OSC_CALIBRATION_A, 32'h2a);
        check({26'h0, fast_calibration}, 32'h2a);
        $display("done: protection");
    endtask
    task automatic t_prescaler();
        int ratio[12] = '{1, 2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48};
        logic [3:0] code;
        int cnt;
        for (int i = 0; i < 12; i++) begin
            code = (i < 7) ? 4'(i - 1) : 4'(i + 1);
            kwr(`REG_MAIN_CLOCK_CONTROL_B, (i == 0) ? 32'h0 : {27'h0, code, 1'b1});
            wait_per();
            @(posedge pclk);
            wait_per();
            cnt = 0;
            do begin
                @(posedge pclk);
                if (cpu_clock_tick === 1'b1)
                    cnt++;
            end while (per_clock_tick !== 1'b1 && cnt < 100);
            check(32'(cnt), 32'(ratio[i]));
        end
        $display("done: prescaler");
    endtask
    task automatic t_requests();
        int gap;
        rtc_enabled <= 1'b1;
        wdt_enabled <= 1'b1;
        bod_enabled <= 1'b1;
        peripheral_request <= 3'b110;
        repeat (3) @(posedge pclk);
        check({29'h0, rtc_clock_request, wdt_clock_request, bod_clock_request}, 32'h6);
        check({30'h0, fast_osc_enable, slow_osc_enable}, 32'h3);
        bod_sampled_mode <= 1'b1;
        for (int n = 0; n < 600 && kilo_tick !== 1'b1; n++) @(posedge pclk);
        gap = 0;
        do begin
            @(posedge pclk);
            gap++;
        end while (kilo_tick !== 1'b1 && gap < 600);
        // Slow model edges come every 8 pclk
        check(32'(gap), 32'(8 * (`KILO_DIVIDE + 1)));
        check({31'h0, bod_clock_request}, 32'h1);
        {rtc_enabled, wdt_enabled, bod_enabled, bod_sampled_mode} <= 4'h0;
        peripheral_request <= 3'b000;
        repeat (20) @(posedge pclk);
        check({31'h0, slow_osc_enable}, 32'h0);
        $display("done: requests");
    endtask
    task automatic t_switch();
        kwr(`REG_MAIN_CLOCK_CONTROL_A, 32'h2);
        rd_chk(`REG_MAIN_CLOCK_CONTROL_A, 32'h0);
        kwr(`REG_MAIN_CLOCK_CONTROL_A, 32'h1);
        wait_src(2'h1);
        check({30'h0, main_source}, 32'h1);
        rd_chk(`REG_MAIN_CLOCK_STATUS, 32'h20);
        kwr(`REG_MAIN_CLOCK_CONTROL_A, 32'h3);
        repeat (50) @(posedge pclk);
        rd_chk(`REG_MAIN_CLOCK_STATUS, 32'h21);
        kwr(`REG_MAIN_CLOCK_CONTROL_A, 32'h0);
        rd_chk(`REG_MAIN_CLOCK_CONTROL_A, 32'h3);
        check({30'h0, main_source}, 32'h1);
        ext_run <= 1'b1;
        peripheral_request <= 3'b001;
        wait_src(2'h3);
        check({30'h0, main_source}, 32'h3);
        rd_chk(`REG_MAIN_CLOCK_STATUS, 32'h80);
        check({31'h0, ext_pin_clock_select}, 32'h1);
        peripheral_request <= 3'b000;
        $display("done: source switch");
    endtask
    task automatic t_sleep();
        wait_gate(1'b1);
        sleep_mode <= SLEEP_IDLE;
        repeat (10) @(posedge pclk);
        check({31'h0, main_clock_gate}, 32'h1);
        sleep_mode <= SLEEP_STANDBY;
        wait_gate(1'b0);
        check({30'h0, main_clock_gate, fast_osc_enable}, 32'h0);
        kwr(`REG_FAST_OSC_CONTROL, 32'h2);
        wait_gate(1'b1);
        check({31'h0, main_clock_gate}, 32'h1);
        nvm_busy <= 1'b1;
        sleep_mode <= SLEEP_POWER_DOWN;
        repeat (20) @(posedge pclk);
        check({31'h0, main_clock_gate}, 32'h1);
        nvm_busy <= 1'b0;
        wait_gate(1'b0);
        repeat (3) @(posedge pclk);
        check({30'h0, main_clock_gate, fast_osc_enable}, 32'h0);
        sleep_mode <= SLEEP_ACTIVE;
        $display("done: sleep");
    endtask
    task automatic t_lock();
        kwr(`REG_MAIN_CLOCK_LOCK, 32'h1);
        kwr(`REG_MAIN_CLOCK_CONTROL_B, 32'h03);
        rd_chk(`REG_MAIN_CLOCK_CONTROL_B, 32'h11);
        kwr(`REG_FAST_OSC_CALIBRATION_A, 32'h2a);
        rd_chk(`REG_FAST_OSC_CALIBRATION_A, 32'h25);
        rd_chk(`REG_MAIN_CLOCK_LOCK, 32'h0);
        fuses <= {6'h13, 4'h6, 1'b0, 1'b1};
        do_reset();
        check({31'h0, fast_osc_center_20mhz}, 32'h0);
        kwr(`REG_FAST_OSC_CALIBRATION_A, 32'h2a);
        rd_chk(`REG_FAST_OSC_CALIBRATION_A, 32'h13);
        rd_chk(`REG_FAST_OSC_CALIBRATION_B, 32'h86);
        check({28'h0, temperature_calibration}, 32'h6);
        $display("done: lock");
    endtask
    // Sized well above the longest prescaler sweep
    initial begin
        repeat (40000) @(posedge pclk);
        num_errors++;
        stop_test();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        t_reset_values();
        t_protect();
        t_prescaler();
        t_requests();
        t_switch();
        do_reset();
        t_sleep();
        t_lock();
        stop_test();
    end
endmodule
